//--- inc/lac_pkg.sv
// package of constants and types for the light alert configuration block
package lac_pkg;

	// --------------------------------------------------------------------
	// register map
	// --------------------------------------------------------------------
	localparam logic [7:0] LAC_ADDR_RESULT = 8'h00;
	localparam logic [7:0] LAC_ADDR_CONFIG = 8'h01;

	// --------------------------------------------------------------------
	// configuration field positions
	// --------------------------------------------------------------------
	localparam int LAC_BIT_ABOVE = 6;
	localparam int LAC_BIT_BELOW = 5;
	localparam int LAC_BIT_LATCH = 4;
	localparam int LAC_BIT_SENSE = 3;
	localparam int LAC_BIT_MASK = 2;
	localparam int LAC_FQ_HI = 1;
	localparam int LAC_FQ_LO = 0;

	// --------------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------------
	localparam logic LAC_RST_LATCH = 1'b1;
	localparam logic LAC_RST_SENSE = 1'b0;
	localparam logic LAC_RST_MASK = 1'b0;
	localparam logic [1:0] LAC_RST_FQ = 2'h0;

	// --------------------------------------------------------------------
	// widths and codes
	// --------------------------------------------------------------------
	localparam int LAC_DATA_W = 16;
	localparam int LAC_LUX_W = 27;
	localparam int LAC_RUN_W = 4;
	localparam int LAC_NFLAG = 2;
	localparam int LAC_IDX_ABOVE = 0;
	localparam int LAC_IDX_BELOW = 1;
	localparam logic [3:0] LAC_RANGE_AUTO = 4'hC;
	localparam logic [3:0] LAC_EXP_MASKED = 4'h0;
	localparam logic [LAC_RUN_W-1:0] LAC_RUN_ONE = 4'h1;
	localparam logic [LAC_DATA_W-1:0] LAC_RD_ZERO = 16'h0000;

	// --------------------------------------------------------------------
	// types
	// --------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] exponent;
		logic [11:0] mantissa;
	} lac_result_t;

	typedef struct packed {
		logic latch_sel;
		logic alert_sense;
		logic exp_mask_on;
		logic [1:0] fault_qty;
	} lac_cfg_t;

	// exponent/mantissa to a common linear scale for comparison
	function automatic logic [LAC_LUX_W-1:0] lac_to_lux(input lac_result_t r);
		logic [LAC_LUX_W-1:0] base;
		base = {{(LAC_LUX_W-12){1'b0}}, r.mantissa};
		return base << r.exponent;
	endfunction

	// fault quantity code to required run length: 1, 2, 4, 8
	function automatic logic [LAC_RUN_W-1:0] lac_need(input logic [1:0] fq);
		return LAC_RUN_ONE << fq;
	endfunction

endpackage

//--- src/lac_fault_run.sv
// consecutive fault run counter for one threshold direction
`timescale 1ns/10ps
module lac_fault_run
	import lac_pkg::*;
(
	input wire logic mclk,                       // system clock
	input wire logic reset_n,                    // async reset, active low
	input wire logic meas_stb,                   // one measurement finished
	input wire logic fault,                      // this measurement is a fault
	input wire logic [LAC_RUN_W-1:0] need,       // faults in a row required
	output logic hit                             // run reaches need at this measurement
);

	logic [LAC_RUN_W-1:0] run_ff;
	logic [LAC_RUN_W-1:0] nxt_run;
	logic [LAC_RUN_W:0] run_plus;

	// --------------------------------------------------------------------
	// run length
	// --------------------------------------------------------------------
	always_comb begin
		run_plus = {1'b0, run_ff} + {{LAC_RUN_W{1'b0}}, 1'b1};
		hit = meas_stb && fault && (run_plus >= {1'b0, need});
		nxt_run = run_ff;
		if (meas_stb) begin
			if (!fault) begin
				nxt_run = '0;
			end else if (run_ff < need) begin
				// saturate at need so a long fault run cannot wrap
				nxt_run = run_plus[LAC_RUN_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			run_ff <= '0;
		end else begin
			run_ff <= nxt_run;
		end
	end

endmodule

//--- src/lac_alert_cfg.sv
// light alert configuration fields, threshold flags and alert pin
`timescale 1ns/10ps
module lac_alert_cfg
	import lac_pkg::*;
(
	input wire logic mclk,                          // system clock, 100 MHz
	input wire logic reset_n,                       // async reset, active low
	input wire logic [7:0] reg_addr,                // register address
	input wire logic [LAC_DATA_W-1:0] reg_wdata,    // register write data
	input wire logic reg_wr,                        // write strobe
	input wire logic reg_rd,                        // read strobe
	output logic [LAC_DATA_W-1:0] reg_rdata,        // read data, cycle after strobe
	input wire logic conv_done,                     // conversion finished pulse
	input wire lac_result_t conv_result,            // finished conversion value
	input wire logic [3:0] range_sel,               // full-scale range field
	input wire lac_result_t low_limit,              // low limit register value
	input wire lac_result_t high_limit,             // high limit register value
	input wire logic flag_clear,                    // user clearing event pulse
	output logic alert_level,                       // alert pin drive level
	output logic alert_oe,                          // alert pin output enable
	output logic above_ind,                         // above-limit flag
	output logic below_ind,                         // below-limit flag
	output lac_cfg_t cfg                            // configuration fields
);

	// --------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------
	lac_cfg_t cfg_ff;
	lac_cfg_t nxt_cfg;
	lac_result_t result_ff;
	lac_result_t nxt_result;
	lac_result_t result_view;
	logic [LAC_DATA_W-1:0] rdata_ff;
	logic [LAC_DATA_W-1:0] nxt_rdata;
	logic [LAC_NFLAG-1:0] flag_ff;
	logic [LAC_NFLAG-1:0] nxt_flag;
	logic [LAC_NFLAG-1:0] fault;
	logic [LAC_NFLAG-1:0] hit;
	logic alert_oe_ff;
	logic nxt_alert_oe;
	logic [LAC_LUX_W-1:0] lux_meas;
	logic [LAC_LUX_W-1:0] lux_low;
	logic [LAC_LUX_W-1:0] lux_high;
	logic [LAC_RUN_W-1:0] need;
	logic alert_active;

	// --------------------------------------------------------------------
	// configuration register
	// --------------------------------------------------------------------
	always_comb begin
		nxt_cfg = cfg_ff;
		if (reg_wr && reg_addr == LAC_ADDR_CONFIG) begin
			// flag bits are read-only; writes to them are dropped
			nxt_cfg.latch_sel = reg_wdata[LAC_BIT_LATCH];
			nxt_cfg.alert_sense = reg_wdata[LAC_BIT_SENSE];
			nxt_cfg.exp_mask_on = reg_wdata[LAC_BIT_MASK];
			nxt_cfg.fault_qty = reg_wdata[LAC_FQ_HI:LAC_FQ_LO];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_ff.latch_sel <= LAC_RST_LATCH;
			cfg_ff.alert_sense <= LAC_RST_SENSE;
			cfg_ff.exp_mask_on <= LAC_RST_MASK;
			cfg_ff.fault_qty <= LAC_RST_FQ;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	assign cfg = cfg_ff;

	// --------------------------------------------------------------------
	// captured result and masked view
	// --------------------------------------------------------------------
	always_comb begin
		nxt_result = result_ff;
		if (conv_done) begin
			nxt_result = conv_result;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			result_ff <= '0;
		end else begin
			result_ff <= nxt_result;
		end
	end

	// masking only touches what software reads back
	always_comb begin
		result_view = result_ff;
		if (cfg_ff.exp_mask_on && range_sel < LAC_RANGE_AUTO) begin
			result_view.exponent = LAC_EXP_MASKED;
		end
	end

	// --------------------------------------------------------------------
	// comparison on the unmasked conversion
	// --------------------------------------------------------------------
	always_comb begin
		// compare the fresh conversion, never the masked view
		lux_meas = lac_to_lux(conv_result);
		lux_low = lac_to_lux(low_limit);
		lux_high = lac_to_lux(high_limit);
		fault[LAC_IDX_ABOVE] = lux_meas > lux_high;
		fault[LAC_IDX_BELOW] = lux_meas < lux_low;
		need = lac_need(cfg_ff.fault_qty);
	end

	// --------------------------------------------------------------------
	// fault runs and threshold flags
	// --------------------------------------------------------------------
	for (genvar i = 0; i < LAC_NFLAG; i++) begin : g_flag
		lac_fault_run u_run (
			.mclk(mclk),
			.reset_n(reset_n),
			.meas_stb(conv_done),
			.fault(fault[i]),
			.need(need),
			.hit(hit[i])
		);

		always_comb begin
			nxt_flag[i] = flag_ff[i];
			if (cfg_ff.latch_sel) begin
				// set beats a clear that lands in the same cycle
				if (hit[i]) begin
					nxt_flag[i] = 1'b1;
				end else if (flag_clear) begin
					nxt_flag[i] = 1'b0;
				end
			end else if (conv_done) begin
				nxt_flag[i] = hit[i];
			end
		end

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				flag_ff[i] <= 1'b0;
			end else begin
				flag_ff[i] <= nxt_flag[i];
			end
		end
	end

	assign above_ind = flag_ff[LAC_IDX_ABOVE];
	assign below_ind = flag_ff[LAC_IDX_BELOW];

	// --------------------------------------------------------------------
	// alert pin, open drain
	// --------------------------------------------------------------------
	always_comb begin
		alert_active = |nxt_flag;
		if (cfg_ff.alert_sense) begin
			// active high: hold low when idle, let the pull-up raise it
			nxt_alert_oe = !alert_active;
		end else begin
			nxt_alert_oe = alert_active;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			alert_oe_ff <= 1'b0;
		end else begin
			alert_oe_ff <= nxt_alert_oe;
		end
	end

	assign alert_level = 1'b0;
	assign alert_oe = alert_oe_ff;

	// --------------------------------------------------------------------
	// read data
	// --------------------------------------------------------------------
	always_comb begin
		nxt_rdata = LAC_RD_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				LAC_ADDR_RESULT: begin
					nxt_rdata = result_view;
				end
				LAC_ADDR_CONFIG: begin
					nxt_rdata[LAC_BIT_ABOVE] = flag_ff[LAC_IDX_ABOVE];
					nxt_rdata[LAC_BIT_BELOW] = flag_ff[LAC_IDX_BELOW];
					nxt_rdata[LAC_BIT_LATCH] = cfg_ff.latch_sel;
					nxt_rdata[LAC_BIT_SENSE] = cfg_ff.alert_sense;
					nxt_rdata[LAC_BIT_MASK] = cfg_ff.exp_mask_on;
					nxt_rdata[LAC_FQ_HI:LAC_FQ_LO] = cfg_ff.fault_qty;
				end
				default: begin
					// unmapped addresses read as zero
					nxt_rdata = LAC_RD_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= LAC_RD_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule

//--- sim/lac_alert_cfg_assertions.sv
// port checker for the light alert configuration block
`timescale 1ns/10ps
module lac_alert_cfg_chk
	import lac_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [LAC_DATA_W-1:0] reg_rdata, // read data
	input wire logic conv_done, // conversion pulse
	input wire lac_result_t conv_result, // conversion value
	input wire logic [3:0] range_sel, // range field
	input wire lac_result_t low_limit, // low limit
	input wire lac_result_t high_limit, // high limit
	input wire logic flag_clear, // clearing event
	input wire logic alert_level, // pin drive level
	input wire logic alert_oe, // pin enable
	input wire logic above_ind, // above flag
	input wire logic below_ind, // below flag
	input wire lac_cfg_t cfg // config fields
);
	logic [26:0] lux_c;
	logic [26:0] lux_h;
	logic [26:0] lux_l;
	// own scaling, so a slip in the shared helper still shows
	assign lux_c = {15'h0000, conv_result.mantissa} << conv_result.exponent;
	assign lux_h = {15'h0000, high_limit.mantissa} << high_limit.exponent;
	assign lux_l = {15'h0000, low_limit.mantissa} << low_limit.exponent;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	AST_LATCH_HOLD: assert property (cfg.latch_sel && !flag_clear && !reg_wr |=>
		above_ind >= $past(above_ind) && below_ind >= $past(below_ind)) else $error("flag dropped");
	AST_LATCH_CLEAR: assert property (cfg.latch_sel && flag_clear && !conv_done |=>
		!above_ind && !below_ind) else $error("flag kept after clear");
	AST_TRANSP_HOLD: assert property (!cfg.latch_sel && !conv_done && !reg_wr |=>
		$stable({above_ind, below_ind})) else $error("flag moved without conversion");
	AST_SENSE_LOW: assert property (!cfg.alert_sense && $stable(cfg) |->
		alert_oe == (above_ind || below_ind) && !alert_level) else $error("pin wrong, sense 0");
	AST_SENSE_HIGH: assert property (cfg.alert_sense && $stable(cfg) |->
		alert_oe == !(above_ind || below_ind) && !alert_level) else $error("pin wrong, sense 1");
	AST_MASK: assert property (reg_rd && reg_addr == LAC_ADDR_RESULT &&
		cfg.exp_mask_on && range_sel < LAC_RANGE_AUTO |=>
		reg_rdata[15:12] == LAC_EXP_MASKED) else $error("exp not masked");
	AST_RISE_ON_CONV: assert property ($rose(above_ind) || $rose(below_ind) |->
		$past(conv_done)) else $error("flag rose without conversion");
	AST_ABOVE_ONE: assert property (conv_done && cfg.fault_qty == 2'h0 &&
		lux_c > lux_h |=> above_ind) else $error("above flag missed");
	AST_BELOW_ONE: assert property (conv_done && cfg.fault_qty == 2'h0 &&
		lux_c < lux_l |=> below_ind) else $error("below flag missed");
	AST_RUN_BREAK: assert property (conv_done && !cfg.latch_sel && !reg_wr &&
		lux_c <= lux_h |=> !above_ind) else $error("above flag kept after good result");
	// --------------------------------------------------------------------
	// coverage
	// --------------------------------------------------------------------
	cover property (conv_done && lux_c > lux_h && cfg.fault_qty == 2'h3);
	cover property (flag_clear && above_ind && cfg.latch_sel);
	cover property (reg_rd && reg_addr == LAC_ADDR_RESULT && cfg.exp_mask_on);
endmodule
bind lac_alert_cfg lac_alert_cfg_chk i_chk(.mclk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .conv_done, .conv_result, .range_sel, .low_limit, .high_limit, .flag_clear,
	.alert_level, .alert_oe, .above_ind, .below_ind, .cfg);

//--- sim/lac_host.sv
// host model: register port master and alert pin pull-up
`timescale 1ns/10ps
module lac_host
	import lac_pkg::*;
(
	input wire logic mclk, // system clock
	output logic [7:0] reg_addr, // register address
	output logic [LAC_DATA_W-1:0] reg_wdata, // write data
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	input wire logic [LAC_DATA_W-1:0] reg_rdata, // read data
	input wire logic alert_level, // pin drive level
	input wire logic alert_oe, // pin enable
	output wire logic alert_pin // resolved pin level
);
	// pull-up wins whenever the device lets go
	assign alert_pin = alert_oe ? alert_level : 1'b1;
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge mclk);
		// released bus shows inverted garbage, never the old value
		{reg_addr, reg_wdata, reg_wr} <= {~a, ~v, 1'b0};
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk);
		{reg_addr, reg_rd} <= {~a, 1'b0};
		@(posedge mclk);
		v = reg_rdata;
	endtask
endmodule

//--- sim/tb.sv
// self-checking bench for the light alert configuration block
`timescale 1ns/10ps
module tb;
	import lac_pkg::*;
	logic mclk, reset_n, reg_wr, reg_rd, conv_done, flag_clear, alert_level, alert_oe;
	logic above_ind, below_ind;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [3:0] range_sel;
	lac_result_t conv_result, low_limit, high_limit;
	lac_cfg_t cfg;
	wire alert_pin;
	wire [1:0] flags = {above_ind, below_ind};
	int n_fail = 0;
	int samples_checked = 0;
	localparam logic [15:0] OK_V = 16'h0080;
	lac_alert_cfg i_lac_alert_cfg(.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .conv_done, .conv_result, .range_sel, .low_limit, .high_limit,
		.flag_clear, .alert_level, .alert_oe, .above_ind, .below_ind, .cfg);
	lac_host i_lac_host(.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.alert_level, .alert_oe, .alert_pin);
	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t ns: got %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic conv(input lac_result_t r);
		@(posedge mclk);
		{conv_result, conv_done} <= {r, 1'b1};
		@(posedge mclk);
		{conv_result, conv_done} <= {~r, 1'b0};
		@(posedge mclk);
	endtask
	// --------------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------------
	task automatic t_reset();
		chk(16'(cfg), 16'h0010);
		i_lac_host.rd(LAC_ADDR_CONFIG, d);
		chk(d, 16'h0010);
		i_lac_host.wr(8'h07, 16'h001F);
		i_lac_host.rd(8'h07, d);
		chk(d, 16'h0000);
		i_lac_host.rd(LAC_ADDR_CONFIG, d);
		chk(d, 16'h0010);
	endtask
	task automatic t_run(input int dir);
		lac_result_t f;
		int n;
		f = dir ? 16'h0008 : 16'h0200;
		for (int q = 0; q < 4; q++) begin
			n = 1 << q;
			i_lac_host.wr(LAC_ADDR_CONFIG, 16'(q));
			conv(OK_V);
			repeat (n - 1) conv(f);
			// a broken run must start over
			if (n > 1) begin
				conv(OK_V);
				repeat (n - 1) conv(f);
			end
			chk(16'(flags), 16'h0000);
			conv(f);
			chk(16'(flags), dir ? 16'h0001 : 16'h0002);
			chk(16'(alert_pin), 16'h0000);
			conv(OK_V);
			chk(16'(flags), 16'h0000);
		end
	endtask
	task automatic t_latch();
		i_lac_host.wr(LAC_ADDR_CONFIG, 16'h0010);
		conv(16'h0200);
		conv(OK_V);
		chk(16'(flags), 16'h0002);
		chk(16'(alert_pin), 16'h0000);
		i_lac_host.rd(LAC_ADDR_CONFIG, d);
		chk(d, 16'h0050);
		i_lac_host.wr(LAC_ADDR_CONFIG, 16'h0018);
		@(posedge mclk);
		chk(16'(alert_pin), 16'h0001);
		@(posedge mclk);
		flag_clear <= 1'b1;
		@(posedge mclk);
		flag_clear <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(16'(flags), 16'h0000);
		chk(16'(alert_pin), 16'h0000);
	endtask
	task automatic t_mask();
		i_lac_host.wr(LAC_ADDR_CONFIG, 16'h0004);
		range_sel <= 4'h3;
		conv(16'h5020);
		chk(16'(flags), 16'h0002);
		// a clearing event has no effect in transparent mode
		flag_clear <= 1'b1;
		@(posedge mclk);
		flag_clear <= 1'b0;
		@(posedge mclk);
		chk(16'(flags), 16'h0002);
		i_lac_host.rd(LAC_ADDR_RESULT, d);
		chk(d, 16'h0020);
		range_sel <= 4'hC;
		i_lac_host.rd(LAC_ADDR_RESULT, d);
		chk(d, 16'h5020);
	endtask
	// --------------------------------------------------------------------
	// clock, watchdog and sequence
	// --------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial begin
		{reset_n, conv_done, flag_clear, conv_result} = '0;
		range_sel = 4'h0;
		low_limit = 16'h0010;
		high_limit = 16'h0100;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset();
		t_run(0);
		t_run(1);
		t_latch();
		t_mask();
		end_sim();
	end
endmodule
